/* dv/rtc_interrupt_enable_flags_bench.sv */
// Self-checking bench for the interrupt enable and flag block
`timescale 1ns/1ps
module rtc_interrupt_enable_flags_bench
  import rtc_irq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  avmm_req_t req = '0;
  avmm_rsp_t rsp;
  irq_event_t ev_in = '0;
  logic int_n;
  logic irq;
  logic [31:0] q;
  logic [31:0] en;
  logic [4:0] ev;
  int err_total = 0;
  int num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  rtc_interrupt_enable_flags i_rtc_interrupt_enable_flags (.ref_clk(ref_clk), .rst(rst),
    .ce(ce), .avs_req(req), .avs_rsp(rsp), .events(ev_in), .int_n(int_n), .irq(irq));
  // Expected interrupt pin level from flags and enables
  function automatic logic exp_int_n(input logic [4:0] f, input logic [4:0] e);
    return ~|(f & e);
  endfunction
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{address: a, read: !w, write: w, writedata: d, byteenable: be};
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      err_total++;
      wrap_up();
    end
    q = rsp.readdata;
    req <= '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask
  initial begin
    void'($urandom(32'h4a4860ba));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADDR_ENABLE, 32'h0, "enable");
    rd(ADDR_FLAGS, 32'h0, "flags");
    chk("int_n", 32'h1, 32'(int_n));
    bus(1'b1, ADDR_ENABLE, 32'hffff_ffff, 4'he);
    rd(ADDR_ENABLE, 32'h0, "enable");
    rd(6'h3c, 32'h0, "unmapped");
    for (int k = 0; k < 8; k++) begin
      en = (k < 5) ? (32'hffff_ffe0 | (32'h1 << k)) : $urandom;
      ev = (k < 5) ? 5'h1f : 5'($urandom);
      bus(1'b1, ADDR_ENABLE, en, 4'h1);
      rd(ADDR_ENABLE, en & 32'h1f, "enable");
      ev_in <= ev;
      @(posedge ref_clk);
      ev_in <= 5'h00;
      repeat (3) @(posedge ref_clk);
      chk("int_n", 32'(exp_int_n(ev, en[4:0])), 32'(int_n));
      chk("irq", 32'h0, 32'(irq));
      rd(ADDR_FLAGS, 32'(ev), "flags");
      bus(1'b1, ADDR_FLAGS, ~en, 4'hf);
      rd(ADDR_FLAGS, 32'(ev & ~en[4:0]), "flags");
      chk("int_n", 32'h1, 32'(int_n));
      bus(1'b1, ADDR_FLAGS, 32'h0, 4'h1);
      rd(ADDR_FLAGS, 32'h0, "flags");
    end
    // Held event against a clearing write, raw level and pending readback
    ev_in <= 5'h02;
    bus(1'b1, ADDR_FLAGS, 32'h0, 4'h1);
    rd(ADDR_LEVEL, 32'h2, "level");
    ev_in <= 5'h00;
    rd(ADDR_FLAGS, 32'h2, "flags");
    rd(ADDR_PEND, 32'h2 & en, "pending");
    chk("int_n", 32'(exp_int_n(5'h02, en[4:0])), 32'(int_n));
    bus(1'b1, ADDR_FLAGS, 32'h0, 4'h1);
    // Events while the clock enable is low leave no trace
    ce <= 1'b0;
    ev_in <= 5'h1f;
    repeat (2) @(posedge ref_clk);
    ev_in <= 5'h00;
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(ADDR_FLAGS, 32'h0, "flags frozen");
    chk("int_n", 32'h1, 32'(int_n));
    bus(1'b1, ADDR_MASK, 32'h1f, 4'h1);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, ADDR_STATUS, 32'h1f, 4'h1);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, 32'(irq));
    rd(ADDR_STATUS, 32'h0, "status");
    // Reset in mid-run with events present
    rst <= 1'b1;
    ev_in <= 5'h1f;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ev_in <= 5'h00;
    rd(ADDR_ENABLE, 32'h0, "enable reset");
    rd(ADDR_FLAGS, 32'h0, "flags reset");
    chk("int_n", 32'h1, 32'(int_n));
    wrap_up();
  end
endmodule // rtc_interrupt_enable_flags_bench

/* dv/rtc_interrupt_enable_flags_properties.sv */
// Checker for the interrupt enable and flag block
`timescale 1ns/1ps
module rtc_interrupt_enable_flags_properties
  import rtc_irq_pkg::*;
#(
  parameter int SRC_W = SRC_N
) (
  input logic ref_clk,
  input logic rst,
  input logic ce,
  input avmm_req_t avs_req,
  input avmm_rsp_t avs_rsp,
  input irq_event_t events,
  input logic int_n,
  input logic irq
);
  logic [4:0] en_r;
  wire ack = ce && !avs_rsp.waitrequest;
  wire rd_ack = ack && avs_req.read;
  wire en_wr = ack && avs_req.write && avs_req.byteenable[0] && avs_req.address == ADDR_ENABLE;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_r <= 5'h00;
    end else if (en_wr) begin
      en_r <= avs_req.writedata[4:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);
  a_answer_next: assert property (avs_rsp.waitrequest && (avs_req.read || avs_req.write)
    ##1 ce |-> !avs_rsp.waitrequest) else $error("no answer in next cycle");
  a_answer_once: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("answer longer than one cycle");
  a_reset_vals: assert property (disable iff (1'b0) rst && ce |=> int_n && !irq
    && avs_rsp.waitrequest && avs_rsp.readdata == '0) else $error("bad reset outputs");
  a_en_readback: assert property (rd_ack && avs_req.address == ADDR_ENABLE
    |-> avs_rsp.readdata == {27'h0, en_r}) else $error("enable readback wrong");
  a_upper_zero: assert property (rd_ack |-> avs_rsp.readdata[31:5] == 27'h0)
    else $error("unused bits not zero");
  a_unmapped_zero: assert property (rd_ack && avs_req.address == 6'h3c
    |-> avs_rsp.readdata == 32'h0) else $error("unmapped read not zero");
  a_flag_sets: assert property (rd_ack && avs_req.address == ADDR_FLAGS && $past(!rst, 2)
    && $past(ce, 1) && $past(ce, 2)
    |-> (avs_rsp.readdata[4:0] & $past(events, 2)) == $past(events, 2)) else $error("flag not set");
  a_ce_freeze: assert property (disable iff (rst) !ce |=> $stable(int_n) && $stable(irq)
    && $stable(avs_rsp)) else $error("outputs moved while clock enable low");
  a_int_on: assert property ((events & en_r) != 5'h00 ##1 $stable(en_r) |=> !int_n)
    else $error("interrupt not asserted");
  a_int_off: assert property (en_r == 5'h00 |=> int_n)
    else $error("interrupt with all sources off");
endmodule // rtc_interrupt_enable_flags_properties

bind rtc_interrupt_enable_flags rtc_interrupt_enable_flags_properties #(.SRC_W(SRC_W)) i_props (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .avs_req(avs_req), .avs_rsp(avs_rsp),
  .events(events), .int_n(int_n), .irq(irq));

/* rtl/evt_flag_bank.sv */
// Bank of sticky event bits where a set beats a simultaneous clear
`timescale 1ns/1ps
module evt_flag_bank
  import rtc_irq_pkg::*;
#(
  parameter int W = SRC_N,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clear,
  output logic [W-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic bit_r;
      logic bit_nxt;
      // Set wins over clear
      assign bit_nxt = set[i] | (bit_r & ~clear[i]);
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          bit_r <= RST_VAL[i];
        end else if (ce) begin
          bit_r <= bit_nxt;
        end
      end
      assign flags[i] = bit_r;
    end
  endgenerate

endmodule // evt_flag_bank

/* rtl/rtc_interrupt_enable_flags.sv */
// Interrupt enable and flag registers with Avalon-MM access and interrupt outputs
//
// Contract
// - Enable bit 4 at index 01h gates the self-recovery interrupt.
// - Enable bit 3 gates low supply two, bit 2 low supply one.
// - Enable bit 1 gates the countdown timer interrupt.
// - Enable bit 0 gates the alarm interrupt.
// - Flag bit 3 at index 02h sets on low supply two, else zero.
// - Flag bit 1 sets when the countdown timer reaches zero.
// - Flag bit 0 sets on alarm match, else reads zero.
// - Bits 7 to 5 of enable and flag registers read zero.
`timescale 1ns/1ps
module rtc_interrupt_enable_flags
  import rtc_irq_pkg::*;
#(
  parameter int SRC_W = SRC_N
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire avmm_req_t avs_req,
  output avmm_rsp_t avs_rsp,
  input wire irq_event_t events,
  output logic int_n,
  output logic irq
);

  // Bus handshake state
  bus_state_t state_r;
  bus_state_t state_nxt;
  logic req_any;
  logic answer_now;
  logic take_write;
  logic lane0;

  // Registers
  irq_enable_t enable_r;
  irq_enable_t enable_nxt;
  logic [SRC_W-1:0] mask_r;
  logic [SRC_W-1:0] mask_nxt;
  logic [SRC_W-1:0] flags;
  logic [SRC_W-1:0] status;
  logic [SRC_W-1:0] event_vec;
  logic [SRC_W-1:0] event_prev_r;
  logic [SRC_W-1:0] event_rise;
  logic [SRC_W-1:0] pending;
  logic [SRC_W-1:0] wdata_lo;

  // Write decode
  logic hit_enable;
  logic hit_flags;
  logic hit_status;
  logic hit_mask;
  logic hit_level;
  logic hit_pend;
  logic wr_enable;
  logic wr_flags;
  logic wr_status;
  logic wr_mask;
  logic [SRC_W-1:0] flag_clear;
  logic [SRC_W-1:0] status_clear;

  // Read path
  logic [REG_W-1:0] rd_byte;
  logic [DATA_W-1:0] rd_word;

  // Output flops
  avmm_rsp_t rsp_r;
  avmm_rsp_t rsp_nxt;
  logic int_n_r;
  logic int_n_nxt;
  logic irq_r;
  logic irq_nxt;

  // Handshake decode
  assign req_any = avs_req.read | avs_req.write;
  assign answer_now = (state_r == BUS_ANSWER);
  assign lane0 = avs_req.byteenable[0];
  assign take_write = answer_now & avs_req.write & lane0;

  // Address decode
  assign hit_enable = (avs_req.address == ADDR_ENABLE);
  assign hit_flags = (avs_req.address == ADDR_FLAGS);
  assign hit_status = (avs_req.address == ADDR_STATUS);
  assign hit_mask = (avs_req.address == ADDR_MASK);
  assign hit_level = (avs_req.address == ADDR_LEVEL);
  assign hit_pend = (avs_req.address == ADDR_PEND);

  // Write strobes, unmapped writes are dropped
  assign wr_enable = take_write & hit_enable;
  assign wr_flags = take_write & hit_flags;
  assign wr_status = take_write & hit_status;
  assign wr_mask = take_write & hit_mask;
  assign wdata_lo = avs_req.writedata[SRC_W-1:0];

  // Event sources as a vector in flag order
  assign event_vec = events;
  assign event_rise = event_vec & ~event_prev_r;

  // Flag clear by writing zero, ones leave the bit alone
  assign flag_clear = wr_flags ? ~wdata_lo : '0;

  // Status clear by writing one
  assign status_clear = wr_status ? wdata_lo : '0;

  // Enabled flags
  assign pending = flags & enable_r;

  // Handshake state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BUS_IDLE: begin
        if (req_any) begin
          state_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        state_nxt = BUS_IDLE;
      end
      default: begin
        state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= BUS_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Enable register
  always_comb begin
    enable_nxt = enable_r;
    if (wr_enable) begin
      enable_nxt = irq_enable_t'(wdata_lo);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_r <= irq_enable_t'(RST_ENABLE);
    end else if (ce) begin
      enable_r <= enable_nxt;
    end
  end

  // Mask register
  assign mask_nxt = wr_mask ? wdata_lo : mask_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= RST_MASK;
    end else if (ce) begin
      mask_r <= mask_nxt;
    end
  end

  // Previous event level for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_prev_r <= '0;
    end else if (ce) begin
      event_prev_r <= event_vec;
    end
  end

  // Latched flags, set by any event level
  evt_flag_bank #(
    .W(SRC_W),
    .RST_VAL(RST_FLAGS)
  ) u_flags (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .set(event_vec),
    .clear(flag_clear),
    .flags(flags)
  );

  // Sticky status, set on each new event
  evt_flag_bank #(
    .W(SRC_W),
    .RST_VAL(RST_STATUS)
  ) u_status (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .set(event_rise),
    .clear(status_clear),
    .flags(status)
  );

  // Read multiplexer, upper bits always zero
  always_comb begin
    rd_byte = '0;
    if (hit_enable) begin
      rd_byte = {{(REG_W-SRC_W){1'b0}}, enable_r} & IMPL_MASK;
    end else if (hit_flags) begin
      rd_byte = {{(REG_W-SRC_W){1'b0}}, flags} & IMPL_MASK;
    end else if (hit_status) begin
      rd_byte = {{(REG_W-SRC_W){1'b0}}, status};
    end else if (hit_mask) begin
      rd_byte = {{(REG_W-SRC_W){1'b0}}, mask_r};
    end else if (hit_level) begin
      rd_byte = {{(REG_W-SRC_W){1'b0}}, event_vec};
    end else if (hit_pend) begin
      rd_byte = {{(REG_W-SRC_W){1'b0}}, pending};
    end
  end

  assign rd_word = {{(DATA_W-REG_W){1'b0}}, rd_byte};

  // Answer: waitrequest drops for the accepting cycle, data held with it
  always_comb begin
    rsp_nxt = rsp_r;
    rsp_nxt.waitrequest = (state_nxt != BUS_ANSWER);
    if (state_r == BUS_IDLE && req_any && avs_req.read) begin
      rsp_nxt.readdata = rd_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_r.readdata <= RST_RDATA;
      rsp_r.waitrequest <= 1'b1;
    end else if (ce) begin
      rsp_r <= rsp_nxt;
    end
  end

  // Interrupt outputs
  assign int_n_nxt = ~(|pending);
  assign irq_nxt = |(status & mask_r);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_n_r <= 1'b1;
      irq_r <= 1'b0;
    end else if (ce) begin
      int_n_r <= int_n_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign avs_rsp = rsp_r;
  assign int_n = int_n_r;
  assign irq = irq_r;

endmodule // rtc_interrupt_enable_flags

/* rtl/rtc_irq_pkg.sv */
// Constants and carrier types for the interrupt enable and flag block
package rtc_irq_pkg;

  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REG_W = 8;
  localparam int SRC_N = 5;

  // Register indices, byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_ENABLE = 6'h01;
  localparam logic [ADDR_W-1:0] IDX_FLAGS = 6'h02;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 6'h05;
  localparam logic [ADDR_W-1:0] IDX_MASK = 6'h06;
  localparam logic [ADDR_W-1:0] IDX_LEVEL = 6'h07;
  localparam logic [ADDR_W-1:0] IDX_PEND = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = {IDX_LEVEL[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PEND = {IDX_PEND[ADDR_W-3:0], 2'h0};

  // Field positions, shared by enable, flag, status and mask
  localparam int BIT_ALARM = 0;
  localparam int BIT_COUNTDOWN = 1;
  localparam int BIT_LOW_ONE = 2;
  localparam int BIT_LOW_TWO = 3;
  localparam int BIT_SELF_REC = 4;

  // Implemented bits, upper three read zero
  localparam logic [REG_W-1:0] IMPL_MASK = 8'h1f;

  // Reset values
  localparam logic [SRC_N-1:0] RST_ENABLE = 5'h00;
  localparam logic [SRC_N-1:0] RST_FLAGS = 5'h00;
  localparam logic [SRC_N-1:0] RST_STATUS = 5'h00;
  localparam logic [SRC_N-1:0] RST_MASK = 5'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // Per-source enables
  typedef struct packed {
    logic self_recovery_irq_enable;
    logic low_supply_two_irq_enable;
    logic low_supply_one_irq_enable;
    logic countdown_irq_enable;
    logic alarm_irq_enable;
  } irq_enable_t;

  // Per-source events and latched flags
  typedef struct packed {
    logic self_recovery_event;
    logic low_supply_two_event;
    logic low_supply_one_event;
    logic countdown_zero_event;
    logic alarm_match_event;
  } irq_event_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } avmm_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  // Slave handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage
